// file: hdl/exec_pkg.sv
// constants, operation codes and cycle counts for the branch/multiply
// execution unit; assumes one core clock and an 8-bit status register
`default_nettype none
package exec_pkg;
    localparam int PC_W = 16;
    localparam int OFS_W = 12;
    // status register bit positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;
    localparam logic [7:0] FLAGS_RST = 8'h00;
    // cycle counts
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_MUL = 2'h2;
    localparam logic [1:0] CYC_JUMP = 2'h2;
    localparam logic [1:0] CYC_CALL = 2'h3;
    localparam logic [1:0] CYC_TAKEN = 2'h2;
    localparam logic [1:0] CYC_SKIP_LONG = 2'h3;
    localparam logic [PC_W-1:0] PC_STEP = 16'h0001;
    localparam logic [PC_W-1:0] SKIP_LONG = 16'h0002;

    typedef enum logic [4:0] {
        OP_NONE = 5'h00,
        OP_MUL_SIGNED = 5'h01,
        OP_MUL_SIGNED_BY_UNSIGNED = 5'h02,
        OP_FRAC_MUL_UNSIGNED = 5'h03,
        OP_FRAC_MUL_SIGNED = 5'h04,
        OP_FRAC_MUL_SIGNED_BY_UNSIGNED = 5'h05,
        OP_REL_JUMP = 5'h06,
        OP_REL_CALL = 5'h07,
        OP_INDIRECT_JUMP = 5'h08,
        OP_INDIRECT_CALL = 5'h09,
        OP_COMPARE_SKIP_EQUAL = 5'h0A,
        OP_COMPARE_IMMEDIATE = 5'h0B,
        OP_SKIP_REG_BIT_CLEAR = 5'h0C,
        OP_SKIP_REG_BIT_SET = 5'h0D,
        OP_SKIP_IO_BIT_CLEAR = 5'h0E,
        OP_SKIP_IO_BIT_SET = 5'h0F,
        OP_BRANCH_FLAG_SET = 5'h10,
        OP_BRANCH_FLAG_CLEAR = 5'h11,
        OP_BRANCH_SIGNED_GE = 5'h12,
        OP_BRANCH_SIGNED_LT = 5'h13
    } exec_op_t;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_RUN = 1'b1
    } exec_state_t;
endpackage : exec_pkg
`default_nettype wire

// file: hdl/mul_unit.sv
// 8x8 multiplier for the signed, mixed and fractional forms
// assumes operands stable while the result is sampled
`default_nettype none
module mul_unit
    import exec_pkg::*;
(
    // operation and operands
    input wire exec_pkg::exec_op_t op_i,
    input wire logic [7:0] a_i,
    input wire logic [7:0] b_i,
    // result
    output logic [15:0] prod_o,
    output logic zero_o,
    output logic carry_o
);
    logic signed [17:0] ext_a;
    logic signed [17:0] ext_b;
    logic signed [17:0] full;
    logic [15:0] raw;
    logic frac;

    always_comb begin
        ext_a = {10'h000, a_i};
        ext_b = {10'h000, b_i};
        frac = 1'b0;
        case (op_i)
            OP_MUL_SIGNED, OP_FRAC_MUL_SIGNED: begin
                ext_a = {{10{a_i[7]}}, a_i};
                ext_b = {{10{b_i[7]}}, b_i};
            end
            OP_MUL_SIGNED_BY_UNSIGNED, OP_FRAC_MUL_SIGNED_BY_UNSIGNED: begin
                ext_a = {{10{a_i[7]}}, a_i};
            end
            default: begin
            end
        endcase
        frac = (op_i == OP_FRAC_MUL_UNSIGNED) ||
               (op_i == OP_FRAC_MUL_SIGNED) ||
               (op_i == OP_FRAC_MUL_SIGNED_BY_UNSIGNED);
        full = ext_a * ext_b;
        raw = full[15:0];
        // carry is the top bit before the fractional shift
        carry_o = raw[15];
        prod_o = frac ? {raw[14:0], 1'b0} : raw;
        zero_o = (prod_o == 16'h0000);
    end
endmodule // mul_unit
`default_nettype wire

// file: hdl/cond_unit.sv
// decides whether a skip or conditional branch is taken
// assumes the flags and operands belong to the instruction in hand
`default_nettype none
module cond_unit
    import exec_pkg::*;
(
    // operation and operands
    input wire exec_pkg::exec_op_t op_i,
    input wire logic [7:0] flags_i,
    input wire logic [2:0] sel_i,
    input wire logic [7:0] rd_i,
    input wire logic [7:0] rr_i,
    input wire logic io_bit_i,
    // decision
    output logic taken_o
);
    function automatic logic pick(input logic [7:0] v, input logic [2:0] s);
        pick = v[s];
    endfunction

    always_comb begin
        case (op_i)
            OP_COMPARE_SKIP_EQUAL: taken_o = (rd_i == rr_i);
            OP_SKIP_REG_BIT_CLEAR: taken_o = !pick(rr_i, sel_i);
            OP_SKIP_REG_BIT_SET: taken_o = pick(rr_i, sel_i);
            OP_SKIP_IO_BIT_CLEAR: taken_o = !io_bit_i;
            OP_SKIP_IO_BIT_SET: taken_o = io_bit_i;
            // named forms arrive as a flag select
            OP_BRANCH_FLAG_SET: taken_o = pick(flags_i, sel_i);
            OP_BRANCH_FLAG_CLEAR:
                taken_o = !pick(flags_i, sel_i);
            OP_BRANCH_SIGNED_GE:
                taken_o = !(flags_i[FLAG_N] ^ flags_i[FLAG_V]);
            OP_BRANCH_SIGNED_LT:
                taken_o = flags_i[FLAG_N] ^ flags_i[FLAG_V];
            default: taken_o = 1'b0;
        endcase
    end
endmodule // cond_unit
`default_nettype wire

// file: hdl/mul_branch_skip_exec.sv
// execution of multiply, jump, call, compare, skip and branch operations
// assumes decode presents one operation per start pulse while idle
// How it works
// - signed and mixed multiplies: product to r1:r0, Z and C, 2 cycles
// - fractional multiplies shift product left one, set Z and C, 2 cycles
// - relative jump pc+k+1, 2 cycles; relative call same target, 3 cycles
// - indirect jump loads pc from Z pointer, no flags, 2 cycles
// - indirect call loads pc from Z pointer, no flags, 3 cycles
// - skip next instruction when registers equal, no flags, 1/2/3 cycles
// - compare immediate sets Z N V C H from rd minus k, 1 cycle
// - skip when register bit clear, no flags, 1/2/3 cycles
// - skip when register bit set, no flags, 1/2/3 cycles
// - skip when io bit clear, pc advances 2 or 3, no flags
// - skip when io bit set, pc advances 2 or 3, no flags
// - flag branch to pc+k+1 on selected flag set or clear, 1/2 cycles
// - equal branch on Z one, not-equal on Z zero
// - carry clear, same-or-higher on C zero; carry set, lower on C one
// - minus branch on N one, plus branch on N zero
// - signed greater-or-equal branch when N xor V is zero
// - half-carry branches on H one or zero, 1/2 cycles
// - T-bit branches on T one or zero, 1/2 cycles
// - overflow branches on V one or zero, 1/2 cycles
// - interrupt-enabled branch on I one, target pc+k+1
`default_nettype none
module mul_branch_skip_exec
    import exec_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // request from decode
    input wire logic start_i,
    input wire exec_pkg::exec_op_t op_i,
    input wire logic [7:0] rd_val_i,
    input wire logic [7:0] rr_val_i,
    input wire logic [7:0] imm_i,
    input wire logic [2:0] sel_i,
    input wire logic io_bit_i,
    input wire logic signed [exec_pkg::OFS_W-1:0] offset_i,
    input wire logic next_two_word_i,
    // core state
    input wire logic [exec_pkg::PC_W-1:0] pc_i,
    input wire logic [exec_pkg::PC_W-1:0] z_ptr_i,
    input wire logic [7:0] core_flags_i,
    // results
    output logic busy_o,
    output logic done_o,
    output logic pc_load_o,
    output logic [exec_pkg::PC_W-1:0] pc_o,
    output logic prod_we_o,
    output logic [15:0] prod_o,
    output logic flags_we_o,
    output logic [7:0] flags_o,
    output logic ret_push_o,
    output logic [exec_pkg::PC_W-1:0] ret_addr_o
);
    exec_state_t state_reg, state_next;
    logic [1:0] cnt_reg, cnt_next;
    logic busy_reg, busy_next;
    logic done_reg, done_next;
    logic pc_load_reg, pc_load_next;
    logic [PC_W-1:0] pc_reg, pc_next;
    logic prod_we_reg, prod_we_next;
    logic [15:0] prod_reg, prod_next;
    logic flags_we_reg, flags_we_next;
    logic [7:0] flags_reg, flags_next;
    logic push_reg, push_next;
    logic [PC_W-1:0] ret_reg, ret_next;
    logic [3:0] pend_reg, pend_next;
    logic take;
    logic taken;
    logic [15:0] mul_prod;
    logic mul_zero;
    logic mul_carry;
    logic [8:0] diff;
    logic [PC_W-1:0] rel_target;
    logic [PC_W-1:0] skip_target;
    logic [1:0] cycles;
    logic [3:0] want;
    mul_unit u_mul (
        .op_i(op_i),
        .a_i(rd_val_i),
        .b_i(rr_val_i),
        .prod_o(mul_prod),
        .zero_o(mul_zero),
        .carry_o(mul_carry)
    );
    cond_unit u_cond (
        .op_i(op_i),
        .flags_i(core_flags_i),
        .sel_i(sel_i),
        .rd_i(rd_val_i),
        .rr_i(rr_val_i),
        .io_bit_i(io_bit_i),
        .taken_o(taken)
    );
    function automatic logic is_mul(input exec_op_t op);
        is_mul = (op >= OP_MUL_SIGNED)
            && (op <= OP_FRAC_MUL_SIGNED_BY_UNSIGNED);
    endfunction
    function automatic logic is_skip(input exec_op_t op);
        is_skip = (op == OP_COMPARE_SKIP_EQUAL)
            || ((op >= OP_SKIP_REG_BIT_CLEAR) && (op <= OP_SKIP_IO_BIT_SET));
    endfunction
    function automatic logic is_branch(input exec_op_t op);
        is_branch = (op >= OP_BRANCH_FLAG_SET) && (op <= OP_BRANCH_SIGNED_LT);
    endfunction
    assign take = start_i && !busy_reg && (op_i != OP_NONE);
    always_comb begin
        rel_target = pc_i + PC_STEP
            + PC_W'(unsigned'({{(PC_W-OFS_W){offset_i[OFS_W-1]}}, offset_i}));
        skip_target = pc_i + PC_STEP
            + (next_two_word_i ? SKIP_LONG : PC_STEP);
        diff = {1'b0, rd_val_i} - {1'b0, imm_i};
        // want: {push, flags, prod, pc}
        want = 4'h0;
        cycles = CYC_ONE;
        pc_next = pc_reg;
        prod_next = prod_reg;
        flags_next = flags_reg;
        ret_next = ret_reg;
        if (is_mul(op_i)) begin
            cycles = CYC_MUL;
            want = 4'h6;
            prod_next = mul_prod;
            flags_next = core_flags_i;
            flags_next[FLAG_Z] = mul_zero;
            flags_next[FLAG_C] = mul_carry;
        end else if (is_skip(op_i)) begin
            if (taken) begin
                cycles = next_two_word_i ? CYC_SKIP_LONG : CYC_TAKEN;
                want = 4'h1;
                pc_next = skip_target;
            end
        end else if (is_branch(op_i)) begin
            if (taken) begin
                cycles = CYC_TAKEN;
                want = 4'h1;
                pc_next = rel_target;
            end
        end else begin
            case (op_i)
                OP_REL_JUMP: begin
                    cycles = CYC_JUMP;
                    want = 4'h1;
                    pc_next = rel_target;
                end
                OP_REL_CALL: begin
                    cycles = CYC_CALL;
                    want = 4'h9;
                    pc_next = rel_target;
                    ret_next = pc_i + PC_STEP;
                end
                OP_INDIRECT_JUMP: begin
                    cycles = CYC_JUMP;
                    want = 4'h1;
                    pc_next = z_ptr_i;
                end
                OP_INDIRECT_CALL: begin
                    cycles = CYC_CALL;
                    want = 4'h9;
                    pc_next = z_ptr_i;
                    ret_next = pc_i + PC_STEP;
                end
                OP_COMPARE_IMMEDIATE: begin
                    want = 4'h4;
                    flags_next = core_flags_i;
                    flags_next[FLAG_Z] = (diff[7:0] == 8'h00);
                    flags_next[FLAG_N] = diff[7];
                    flags_next[FLAG_C] = diff[8];
                    flags_next[FLAG_V] = (rd_val_i[7] ^ imm_i[7])
                        & (rd_val_i[7] ^ diff[7]);
                    flags_next[FLAG_H] = (!rd_val_i[3] & imm_i[3])
                        | (imm_i[3] & diff[3]) | (diff[3] & !rd_val_i[3]);
                end
                default: begin
                end
            endcase
        end
        if (!take) begin
            pc_next = pc_reg;
            prod_next = prod_reg;
            flags_next = flags_reg;
            ret_next = ret_reg;
        end
    end
    // sequencer: result strobes fire exactly `cycles` edges after take
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        pend_next = pend_reg;
        done_next = 1'b0;
        busy_next = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (take) begin
                    pend_next = want;
                    if (cycles == CYC_ONE) begin
                        done_next = 1'b1;
                    end else begin
                        state_next = ST_RUN;
                        cnt_next = cycles - CYC_ONE;
                        busy_next = 1'b1;
                    end
                end
            end
            ST_RUN: begin
                cnt_next = cnt_reg - CYC_ONE;
                if (cnt_reg == CYC_ONE) begin
                    done_next = 1'b1;
                    state_next = ST_IDLE;
                end else begin
                    busy_next = 1'b1;
                end
            end
            default: state_next = ST_IDLE;
        endcase
        pc_load_next = done_next & pend_next[0];
        prod_we_next = done_next & pend_next[1];
        flags_we_next = done_next & pend_next[2];
        push_next = done_next & pend_next[3];
    end
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 2'h0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            pend_reg <= 4'h0;
            pc_load_reg <= 1'b0;
            pc_reg <= '0;
            prod_we_reg <= 1'b0;
            prod_reg <= 16'h0000;
            flags_we_reg <= 1'b0;
            flags_reg <= FLAGS_RST;
            push_reg <= 1'b0;
            ret_reg <= '0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
            pend_reg <= pend_next;
            pc_load_reg <= pc_load_next;
            pc_reg <= pc_next;
            prod_we_reg <= prod_we_next;
            prod_reg <= prod_next;
            flags_we_reg <= flags_we_next;
            flags_reg <= flags_next;
            push_reg <= push_next;
            ret_reg <= ret_next;
        end
    end
    assign busy_o = busy_reg;
    assign done_o = done_reg;
    assign pc_load_o = pc_load_reg;
    assign pc_o = pc_reg;
    assign prod_we_o = prod_we_reg;
    assign prod_o = prod_reg;
    assign flags_we_o = flags_we_reg;
    assign flags_o = flags_reg;
    assign ret_push_o = push_reg;
    assign ret_addr_o = ret_reg;

    property p_mul_two;
        @(posedge mclk_i) disable iff (sys_rst_i)
        take && (op_i == OP_MUL_SIGNED) |->
            ##1 !done_o ##1 (done_o && prod_we_o
            && prod_o == 16'(signed'($past(rd_val_i, 2))
                * signed'($past(rr_val_i, 2))));
    endproperty
    a_mul_two: assert property (p_mul_two)
        else $error("signed multiply result or timing wrong");
    property p_frac_shift;
        @(posedge mclk_i) disable iff (sys_rst_i)
        take && (op_i == OP_FRAC_MUL_UNSIGNED) |-> ##2
            (prod_we_o && prod_o == {16'($past(rd_val_i, 2)
                * $past(rr_val_i, 2)) << 1}
            && flags_o[FLAG_Z] == (prod_o == 16'h0000));
    endproperty
    a_frac_shift: assert property (p_frac_shift)
        else $error("fractional multiply not shifted");
    property p_rel_call;
        @(posedge mclk_i) disable iff (sys_rst_i)
        take && (op_i == OP_REL_CALL) |-> ##1 busy_o [*2] ##1
            (pc_load_o && ret_push_o
            && ret_addr_o == $past(pc_i, 3) + 16'h0001);
    endproperty
    a_rel_call: assert property (p_rel_call)
        else $error("relative call timing or return address wrong");
    property p_indirect_jump;
        @(posedge mclk_i) disable iff (sys_rst_i)
        take && (op_i == OP_INDIRECT_JUMP) |-> ##2
            (pc_load_o && !flags_we_o && pc_o == $past(z_ptr_i, 2));
    endproperty
    a_indirect_jump: assert property (p_indirect_jump)
        else $error("indirect jump target wrong");
    property p_indirect_call;
        @(posedge mclk_i) disable iff (sys_rst_i)
        take && (op_i == OP_INDIRECT_CALL) |-> ##1 !done_o ##1 !done_o
            ##1 (done_o && pc_o == $past(z_ptr_i, 3) && !flags_we_o);
    endproperty
    a_indirect_call: assert property (p_indirect_call)
        else $error("indirect call not three cycles");
    property p_compare_skip_equal;
        @(posedge mclk_i) disable iff (sys_rst_i)
        take && (op_i == OP_COMPARE_SKIP_EQUAL) && (rd_val_i != rr_val_i)
            |-> ##1 (done_o && !pc_load_o && !flags_we_o);
    endproperty
    a_compare_skip_equal: assert property (p_compare_skip_equal)
        else $error("unequal compare-skip must not skip");
    property p_cpi;
        @(posedge mclk_i) disable iff (sys_rst_i)
        take && (op_i == OP_COMPARE_IMMEDIATE) |-> ##1 (flags_we_o
            && flags_o[FLAG_Z] == ($past(rd_val_i) == $past(imm_i))
            && flags_o[FLAG_C] == ($past(rd_val_i) < $past(imm_i)));
    endproperty
    a_cpi: assert property (p_cpi)
        else $error("compare immediate flags wrong");
    property p_branch_lt;
        @(posedge mclk_i) disable iff (sys_rst_i)
        take && (op_i == OP_BRANCH_SIGNED_LT)
            && (core_flags_i[FLAG_N] == core_flags_i[FLAG_V])
            |-> ##1 (done_o && !pc_load_o);
    endproperty
    a_branch_lt: assert property (p_branch_lt)
        else $error("less-than branch taken on equal N and V");
    property p_branch_set;
        @(posedge mclk_i) disable iff (sys_rst_i)
        take && (op_i == OP_BRANCH_FLAG_SET) && core_flags_i[sel_i]
            |-> ##2 (pc_load_o && pc_o == $past(pc_i, 2) + 16'h0001
            + 16'($past(offset_i, 2)));
    endproperty
    a_branch_set: assert property (p_branch_set)
        else $error("taken flag branch wrong");
endmodule // mul_branch_skip_exec
`default_nettype wire

// file: tb/mul_branch_skip_exec_tb.sv
// self-checking bench for the multiply/branch/skip execution unit
// assumes exec_pkg compiled first; bench drives every port itself
`default_nettype none
module mul_branch_skip_exec_tb;
    import exec_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk_i;
    logic sys_rst_i = 1'b1;
    logic start_i = 1'b0;
    exec_op_t op_i = OP_NONE;
    logic [7:0] rd_val_i = 8'h00;
    logic [7:0] rr_val_i = 8'h00;
    logic [7:0] imm_i = 8'h00;
    logic [2:0] sel_i = 3'h0;
    logic io_bit_i = 1'b0;
    logic signed [OFS_W-1:0] offset_i = 12'h000;
    logic next_two_word_i = 1'b0;
    logic [PC_W-1:0] pc_i = 16'h0000;
    logic [PC_W-1:0] z_ptr_i = 16'h0000;
    logic [7:0] core_flags_i = 8'h00;
    logic busy_o, done_o, pc_load_o, prod_we_o, flags_we_o, ret_push_o;
    logic [PC_W-1:0] pc_o, ret_addr_o;
    logic [15:0] prod_o;
    logic [7:0] flags_o;
    logic [31:0] fails = 32'h0;
    logic [31:0] cmp_count = 32'h0;
    int cyc_cnt = 0;

    mul_branch_skip_exec DUT (.mclk_i, .sys_rst_i, .start_i, .op_i,
        .rd_val_i, .rr_val_i, .imm_i, .sel_i, .io_bit_i, .offset_i,
        .next_two_word_i, .pc_i, .z_ptr_i, .core_flags_i, .busy_o, .done_o,
        .pc_load_o, .pc_o, .prod_we_o, .prod_o, .flags_we_o, .flags_o,
        .ret_push_o, .ret_addr_o);

    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end

    task automatic final_report();
        if (fails == 0 && cmp_count != 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // hang guard, whole run needs well under a thousand cycles
    always @(posedge mclk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 5000) begin
            fails++;
            final_report();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    // one request, then wait for done and judge latency and pc load
    task automatic run(input exec_op_t op, input int n, input logic ld,
                       input logic [15:0] tgt);
        int k;
        op_i = op;
        start_i = 1'b1;
        @(negedge mclk_i);
        start_i = 1'b0;
        op_i = OP_NONE;
        chk(busy_o, n > 1);
        k = 1;
        while (done_o !== 1'b1 && k < 8) begin
            @(negedge mclk_i);
            k++;
        end
        chk(k, n);
        chk(pc_load_o, ld);
        if (ld) begin
            chk(pc_o, tgt);
        end
    endtask

    task automatic t_mul(input exec_op_t op, input logic [7:0] a, b);
        logic [15:0] p;
        logic [15:0] r;
        rd_val_i = a;
        rr_val_i = b;
        core_flags_i = 8'hA5;
        case (op)
            OP_MUL_SIGNED, OP_FRAC_MUL_SIGNED: p = $signed(a) * $signed(b);
            OP_MUL_SIGNED_BY_UNSIGNED, OP_FRAC_MUL_SIGNED_BY_UNSIGNED:
                p = $signed({{8{a[7]}}, a}) * $signed({8'h00, b});
            default: p = {8'h00, a} * {8'h00, b};
        endcase
        r = (op inside {OP_FRAC_MUL_UNSIGNED, OP_FRAC_MUL_SIGNED,
            OP_FRAC_MUL_SIGNED_BY_UNSIGNED}) ? p << 1 : p;
        run(op, 2, 1'b0, 16'h0000);
        chk(prod_we_o, 1'b1);
        chk(prod_o, r);
        chk(flags_we_o, 1'b1);
        chk(flags_o, {core_flags_i[7:2], r == 16'h0000, p[15]});
    endtask

    task automatic t_jump(input exec_op_t op, input logic [11:0] k,
                          input int n, input logic [15:0] tgt);
        pc_i = 16'h1234;
        z_ptr_i = 16'hBEEF;
        offset_i = k;
        core_flags_i = 8'h5A;
        run(op, n, 1'b1, tgt);
        chk(flags_we_o, 1'b0);
        chk(prod_we_o, 1'b0);
        chk(ret_push_o, n == 3);
        if (n == 3) begin
            chk(ret_addr_o, 16'h1235);
        end
    endtask

    task automatic t_cpi(input logic [7:0] d, k, f);
        logic [7:0] r;
        logic [7:0] e;
        rd_val_i = d;
        imm_i = k;
        core_flags_i = f;
        r = d - k;
        e = f;
        e[FLAG_C] = (~d[7] & k[7]) | (k[7] & r[7]) | (r[7] & ~d[7]);
        e[FLAG_Z] = (r == 8'h00);
        e[FLAG_N] = r[7];
        e[FLAG_V] = (d[7] & ~k[7] & ~r[7]) | (~d[7] & k[7] & r[7]);
        e[FLAG_H] = (~d[3] & k[3]) | (k[3] & r[3]) | (r[3] & ~d[3]);
        run(OP_COMPARE_IMMEDIATE, 1, 1'b0, 16'h0000);
        chk(flags_we_o, 1'b1);
        chk(flags_o, e);
        chk(prod_we_o, 1'b0);
    endtask

    task automatic t_skip(input exec_op_t op, input logic [7:0] d, r,
                          input logic [2:0] s, input logic io, two, hit);
        pc_i = 16'h0100;
        rd_val_i = d;
        rr_val_i = r;
        sel_i = s;
        io_bit_i = io;
        next_two_word_i = two;
        core_flags_i = 8'h33;
        run(op, hit ? (two ? 3 : 2) : 1, hit, two ? 16'h0103 : 16'h0102);
        chk(flags_we_o, 1'b0);
    endtask

    task automatic t_br(input exec_op_t op, input logic [2:0] s,
                        input logic [7:0] f, input logic hit);
        pc_i = 16'h2000;
        offset_i = 12'hFC0;
        sel_i = s;
        core_flags_i = f;
        run(op, hit ? 2 : 1, hit, 16'h1FC1);
        chk(flags_we_o, 1'b0);
    endtask

    // idle requests and requests during busy are dropped
    task automatic t_refuse();
        rd_val_i = 8'h03;
        rr_val_i = 8'h05;
        op_i = OP_MUL_SIGNED;
        start_i = 1'b1;
        @(negedge mclk_i);
        op_i = OP_REL_JUMP;
        chk(busy_o, 1'b1);
        @(negedge mclk_i);
        op_i = OP_NONE;
        chk(done_o, 1'b1);
        chk(prod_o, 16'h000F);
        repeat (3) begin
            @(negedge mclk_i);
            chk(done_o, 1'b0);
        end
        start_i = 1'b0;
    endtask

    initial begin
        repeat (5) @(negedge mclk_i);
        sys_rst_i = 1'b0;
        @(negedge mclk_i);
        chk({busy_o, done_o, pc_load_o, prod_we_o, flags_we_o}, 0);
        chk({pc_o, prod_o}, 0);
        t_mul(OP_MUL_SIGNED, 8'h81, 8'h7F);
        t_mul(OP_MUL_SIGNED, 8'h00, 8'h55);
        t_mul(OP_MUL_SIGNED_BY_UNSIGNED, 8'hFF, 8'hFF);
        t_mul(OP_FRAC_MUL_UNSIGNED, 8'hFF, 8'hFF);
        t_mul(OP_FRAC_MUL_SIGNED, 8'h80, 8'h80);
        t_mul(OP_FRAC_MUL_SIGNED_BY_UNSIGNED, 8'h80, 8'hC0);
        t_jump(OP_REL_JUMP, 12'hFFF, 2, 16'h1234);
        t_jump(OP_REL_JUMP, 12'h7FF, 2, 16'h1A34);
        t_jump(OP_REL_CALL, 12'h800, 3, 16'h0A35);
        t_jump(OP_INDIRECT_JUMP, 12'h010, 2, 16'hBEEF);
        t_jump(OP_INDIRECT_CALL, 12'h010, 3, 16'hBEEF);
        t_cpi(8'h10, 8'h10, 8'hFF);
        t_cpi(8'h80, 8'h01, 8'h00);
        t_cpi(8'h00, 8'h01, 8'h40);
        t_skip(OP_COMPARE_SKIP_EQUAL, 8'h5A, 8'h5A, 0, 0, 0, 1);
        t_skip(OP_COMPARE_SKIP_EQUAL, 8'hC3, 8'hC3, 0, 0, 1, 1);
        t_skip(OP_COMPARE_SKIP_EQUAL, 8'h5A, 8'h5B, 0, 0, 1, 0);
        t_skip(OP_SKIP_REG_BIT_CLEAR, 8'h04, 8'hFB, 2, 0, 1, 1);
        t_skip(OP_SKIP_REG_BIT_CLEAR, 8'hFB, 8'h04, 2, 0, 0, 0);
        t_skip(OP_SKIP_REG_BIT_SET, 8'h7F, 8'h80, 7, 0, 0, 1);
        t_skip(OP_SKIP_REG_BIT_SET, 8'h80, 8'h7F, 7, 0, 1, 0);
        t_skip(OP_SKIP_IO_BIT_CLEAR, 8'h00, 8'h00, 0, 0, 0, 1);
        t_skip(OP_SKIP_IO_BIT_CLEAR, 8'h00, 8'h00, 0, 1, 0, 0);
        t_skip(OP_SKIP_IO_BIT_SET, 8'h00, 8'h00, 0, 1, 1, 1);
        t_skip(OP_SKIP_IO_BIT_SET, 8'h00, 8'h00, 0, 0, 0, 0);
        for (int s = 0; s < 8; s++) begin
            logic [7:0] m;
            m = 8'h01 << s;
            t_br(OP_BRANCH_FLAG_SET, 3'(s), m, 1);
            t_br(OP_BRANCH_FLAG_SET, 3'(s), ~m, 0);
            t_br(OP_BRANCH_FLAG_CLEAR, 3'(s), ~m, 1);
            t_br(OP_BRANCH_FLAG_CLEAR, 3'(s), m, 0);
        end
        t_br(OP_BRANCH_SIGNED_GE, 3'h0, 8'h0C, 1);
        t_br(OP_BRANCH_SIGNED_GE, 3'h0, 8'h04, 0);
        t_br(OP_BRANCH_SIGNED_LT, 3'h0, 8'h08, 1);
        t_br(OP_BRANCH_SIGNED_LT, 3'h0, 8'h0C, 0);
        t_refuse();
        final_report();
    end
endmodule // mul_branch_skip_exec_tb
`default_nettype wire
